// File: design/ltst_evt.sv
// One event layer: transition filter, sticky event bits, enable mask, summary.
// Assumes clr is a one-cycle pulse and the condition word is registered.
`timescale 1ns/1ps
`include "ltst_cfg.svh"

module ltst_evt (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // Condition word and register writes
    input  wire logic [`LTST_DW-1:0] cond,
    input  wire logic [`LTST_DW-1:0] wdata,
    input  wire logic                wr_ena,
    input  wire logic                wr_ptr,
    input  wire logic                wr_ntr,
    input  wire logic                clr,
    // Layer state
    output logic      [`LTST_DW-1:0] evt,
    output logic      [`LTST_DW-1:0] ena,
    output logic      [`LTST_DW-1:0] ptr,
    output logic      [`LTST_DW-1:0] ntr,
    output logic                     sum,
    output logic                     new_evt
);

    ltst_pkg::ltst_evt_st_t st_r;
    ltst_pkg::ltst_evt_st_t st_nxt;
    logic [`LTST_DW-1:0]    setv;

    // Filtered transitions of the condition word
    assign setv = (cond & ~st_r.prev & st_r.ptr) | (~cond & st_r.prev & st_r.ntr);

    // Next state; a set in the clearing cycle wins
    always_comb begin
        st_nxt      = st_r;
        st_nxt.prev = cond;
        st_nxt.evt  = setv | (clr ? '0 : st_r.evt);
        if (wr_ena) begin
            st_nxt.ena = wdata;
        end
        if (wr_ptr) begin
            st_nxt.ptr = wdata;
        end
        if (wr_ntr) begin
            st_nxt.ntr = wdata;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= '{prev: '0, evt: '0, ena: `LTST_ENA_RST, ptr: `LTST_PTR_RST, ntr: `LTST_NTR_RST};
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs
    assign evt     = st_r.evt;
    assign ena     = st_r.ena;
    assign ptr     = st_r.ptr;
    assign ntr     = st_r.ntr;
    assign sum     = |(st_r.evt & st_r.ena);
    assign new_evt = |setv;

    // Checks
    evt_latch_a: assert property (@(posedge clk) disable iff (rst)
        setv != '0 |=> (st_r.evt & $past(setv)) == $past(setv))
        else $error("filtered transition not latched");
    cls_clear_a: assert property (@(posedge clk) disable iff (rst)
        clr |=> st_r.evt == $past(setv))
        else $error("event bits survived clear");
    ena_gate_a: assert property (@(posedge clk) disable iff (rst)
        (st_r.ena == '0) |-> !sum)
        else $error("summary set with empty mask");
    stay_a: assert property (@(posedge clk) disable iff (rst)
        !clr && st_r.evt[1] |=> st_r.evt[1])
        else $error("event bit dropped without clear");

endmodule

// File: design/ltst_top.sv
// Limit test status tree: per-channel trace fail layer and channel summary layer.
// Assumes measurement reports and the register port are synchronous to clk.
`timescale 1ns/1ps
`include "ltst_cfg.svh"

module ltst_top (
    // Clock and reset
    input  wire logic                                 clk,
    input  wire logic                                 rst,
    // Register port
    input  wire logic            [`LTST_AW-1:0]       addr,
    input  wire logic            [`LTST_DW-1:0]       wdata,
    input  wire logic                                 wr,
    input  wire logic                                 rd,
    output logic                 [`LTST_DW-1:0]       rdata,
    // Measurement reports, one per channel
    input  wire ltst_pkg::ltst_meas_t [`LTST_NCH-1:0] meas,
    // Status outputs
    output logic                 [`LTST_DW-1:0]       limit_sum,
    output logic                                      ques_limit,
    output logic                                      irq
);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    ltst_pkg::ltst_top_st_t st_r;
    ltst_pkg::ltst_top_st_t st_nxt;

    // Per-layer views; layers 0-3 are channels, layer 4 the summary
    logic [`LTST_NLAYER-1:0][`LTST_DW-1:0] lcond;
    logic [`LTST_NLAYER-1:0][`LTST_DW-1:0] levt;
    logic [`LTST_NLAYER-1:0][`LTST_DW-1:0] lena;
    logic [`LTST_NLAYER-1:0][`LTST_DW-1:0] lptr;
    logic [`LTST_NLAYER-1:0][`LTST_DW-1:0] lntr;
    logic [`LTST_NLAYER-1:0]               lsum;
    logic [`LTST_NLAYER-1:0]               lnew;

    // Decoded strobes
    logic                                  misc_sel;
    logic                                  cls_hit;
    logic                                  istat_rd;
    logic                                  imask_wr;

    // Decode of the miscellaneous block
    assign misc_sel = addr[5:3] == `LTST_MISC_LAYER;
    assign cls_hit  = wr && misc_sel && addr[2:0] == `LTST_MISC_CLS;
    assign istat_rd = rd && misc_sel && addr[2:0] == `LTST_MISC_ISTAT;
    assign imask_wr = wr && misc_sel && addr[2:0] == `LTST_MISC_IMASK;

    // Condition words feeding the layers
    assign lcond[`LTST_NCH-1:0] = st_r.cond;
    assign lcond[`LTST_NCH]     = st_r.sum_cond;

    // Event layers, one per channel plus the summary
    for (genvar gl = 0; gl < `LTST_NLAYER; gl++) begin : g_layer
        logic hit;
        assign hit = addr[5:3] == 3'(gl);
        ltst_evt u_evt (
            .clk     (clk),
            .rst     (rst),
            .cond    (lcond[gl]),
            .wdata   (wdata),
            .wr_ena  (wr && hit && addr[2:0] == `LTST_REG_ENA),
            .wr_ptr  (wr && hit && addr[2:0] == `LTST_REG_PTR),
            .wr_ntr  (wr && hit && addr[2:0] == `LTST_REG_NTR),
            .clr     (cls_hit || (rd && hit && addr[2:0] == `LTST_REG_EVT)),
            .evt     (levt[gl]),
            .ena     (lena[gl]),
            .ptr     (lptr[gl]),
            .ntr     (lntr[gl]),
            .sum     (lsum[gl]),
            .new_evt (lnew[gl])
        );
    end

    // Next state of conditions, summary, interrupt and read data
    always_comb begin
        st_nxt = st_r;

        // Trace fail bits per channel; an end report wins over a start
        for (int c = 0; c < `LTST_NCH; c++) begin
            if (meas[c].done) begin
                st_nxt.cond[c] = '0;
                st_nxt.cond[c][`LTST_TRC_MSB:`LTST_TRC_LSB] = meas[c].fail;
            end else if (meas[c].start) begin
                st_nxt.cond[c] = '0;
            end
        end

        // Channel summary condition word, bits 1 to 4
        st_nxt.sum_cond = '0;
        st_nxt.sum_cond[`LTST_TRC_MSB:`LTST_TRC_LSB] = lsum[`LTST_NCH-1:0];

        // Questionable limit bit from the summary layer
        st_nxt.ques = lsum[`LTST_NCH];

        // Sticky interrupt status; a read clears, a new event wins
        st_nxt.istat = (istat_rd ? '0 : st_r.istat)
                     | {lsum[`LTST_NCH] & ~st_r.ques, lnew[`LTST_NCH-1:0]};
        if (imask_wr) begin
            st_nxt.imask = wdata[`LTST_IW-1:0];
        end
        st_nxt.irq = |(st_nxt.istat & st_nxt.imask);

        // Read data stand one cycle only
        st_nxt.rdata = '0;
        if (rd) begin
            if (addr[5:3] < `LTST_MISC_LAYER) begin
                unique case (addr[2:0])
                    `LTST_REG_COND: st_nxt.rdata = lcond[addr[5:3]];
                    `LTST_REG_EVT:  st_nxt.rdata = levt[addr[5:3]];
                    `LTST_REG_ENA:  st_nxt.rdata = lena[addr[5:3]];
                    `LTST_REG_PTR:  st_nxt.rdata = lptr[addr[5:3]];
                    `LTST_REG_NTR:  st_nxt.rdata = lntr[addr[5:3]];
                    default:        st_nxt.rdata = '0;
                endcase
            end else if (misc_sel) begin
                unique case (addr[2:0])
                    `LTST_MISC_QCOND: st_nxt.rdata[`LTST_QUES_BIT] = st_r.ques;
                    `LTST_MISC_ISTAT: st_nxt.rdata[`LTST_IW-1:0] = st_r.istat;
                    `LTST_MISC_IMASK: st_nxt.rdata[`LTST_IW-1:0] = st_r.imask;
                    default:          st_nxt.rdata = '0;
                endcase
            end
        end
    end

    // State register; everything resets to zero
    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register
    assign rdata      = st_r.rdata;
    assign limit_sum  = st_r.sum_cond;
    assign ques_limit = st_r.ques;
    assign irq        = st_r.irq;

    // Per-channel checks
    for (genvar gc = 0; gc < `LTST_NCH; gc++) begin : g_chk
        sum_bit_a: assert property (
            |(levt[gc] & lena[gc]) |=> limit_sum[gc + 1])
            else $error("summary bit low with enabled event");
        start_zero_a: assert property (
            meas[gc].start && !meas[gc].done |=> st_r.cond[gc] == 16'h0000)
            else $error("trace fail bits not zeroed at start");
        done_fail_a: assert property (
            meas[gc].done |=> st_r.cond[gc][4:1] == $past(meas[gc].fail))
            else $error("trace fail bits wrong after cycle end");
        rsvd_zero_a: assert property (
            st_r.cond[gc][0] == 1'b0 && st_r.cond[gc][15:5] == 11'h000)
            else $error("reserved condition bit set");
        hold_cond_a: assert property (
            !meas[gc].start && !meas[gc].done |=> $stable(st_r.cond[gc]))
            else $error("condition changed without report");
        sum_low_a: assert property (
            !(|(levt[gc] & lena[gc])) |=> !limit_sum[gc + 1])
            else $error("summary bit high without enabled event");
        istat_set_a: assert property (
            lnew[gc] |=> st_r.istat[gc])
            else $error("channel event missing from interrupt status");
    end

    // Per-layer register and filter checks; layer 4 is the summary
    for (genvar gk = 0; gk < `LTST_NLAYER; gk++) begin : g_lchk
        cond_rd_a: assert property (
            rd && addr == {3'(gk), `LTST_REG_COND} |=> rdata == $past(lcond[gk]))
            else $error("condition read data wrong");
        evt_rd_a: assert property (
            rd && addr == {3'(gk), `LTST_REG_EVT} |=> rdata == $past(levt[gk]))
            else $error("event read data wrong");
        ena_rd_a: assert property (
            rd && addr == {3'(gk), `LTST_REG_ENA} |=> rdata == $past(lena[gk]))
            else $error("enable read data wrong");
        ptr_rd_a: assert property (
            rd && addr == {3'(gk), `LTST_REG_PTR} |=> rdata == $past(lptr[gk]))
            else $error("rising filter read data wrong");
        ntr_rd_a: assert property (
            rd && addr == {3'(gk), `LTST_REG_NTR} |=> rdata == $past(lntr[gk]))
            else $error("falling filter read data wrong");
        ena_wr_a: assert property (
            wr && addr == {3'(gk), `LTST_REG_ENA} |=> lena[gk] == $past(wdata))
            else $error("enable write lost");
        ptr_wr_a: assert property (
            wr && addr == {3'(gk), `LTST_REG_PTR} |=> lptr[gk] == $past(wdata))
            else $error("rising filter write lost");
        ntr_wr_a: assert property (
            wr && addr == {3'(gk), `LTST_REG_NTR} |=> lntr[gk] == $past(wdata))
            else $error("falling filter write lost");
        cls_all_a: assert property (
            cls_hit && !lnew[gk] |=> levt[gk] == 16'h0000)
            else $error("layer events survived clear");
        evt_rdclr_a: assert property (
            rd && addr == {3'(gk), `LTST_REG_EVT} && !lnew[gk] |=> levt[gk] == 16'h0000)
            else $error("event bits survived their read");
        rise_evt_a: assert property (
            (lcond[gk] & ~$past(lcond[gk]) & lptr[gk]) != 16'h0000
            |=> (levt[gk] & $past(lcond[gk]) & ~$past(lcond[gk], 2) & $past(lptr[gk]))
                == ($past(lcond[gk]) & ~$past(lcond[gk], 2) & $past(lptr[gk])))
            else $error("rising transition not latched");
        fall_evt_a: assert property (
            (~lcond[gk] & $past(lcond[gk]) & lntr[gk]) != 16'h0000
            |=> (levt[gk] & ~$past(lcond[gk]) & $past(lcond[gk], 2) & $past(lntr[gk]))
                == (~$past(lcond[gk]) & $past(lcond[gk], 2) & $past(lntr[gk])))
            else $error("falling transition not latched");
    end

    // Tree-level checks
    cls_sum_a: assert property (
        cls_hit && lnew[`LTST_NCH] == 1'b0 |=> levt[`LTST_NCH] == 16'h0000)
        else $error("summary events survived clear");
    cls_chan_a: assert property (
        cls_hit && lnew[0] == 1'b0 |=> levt[0] == 16'h0000)
        else $error("channel events survived clear");
    ques_bit_a: assert property (
        ques_limit == $past(lsum[`LTST_NCH]))
        else $error("questionable limit bit mismatch");
    ena_off_a: assert property (
        lena[`LTST_NCH] == 16'h0000 |=> !ques_limit)
        else $error("questionable bit set with empty mask");
    rd_once_a: assert property (
        !rd |=> rdata == 16'h0000)
        else $error("read data outside read slot");
    irq_lvl_a: assert property (
        |(st_r.istat & st_r.imask) |-> irq)
        else $error("interrupt low with unmasked status");
    sum_rsvd_a: assert property (
        limit_sum[0] == 1'b0 && limit_sum[15:5] == 11'h000)
        else $error("unused summary bit set");
    sum_clr_a: assert property (
        cls_hit && lnew[`LTST_NCH-1:0] == 4'h0 |=> ##1 limit_sum == 16'h0000)
        else $error("summary bits survived clear");
    ques_low_a: assert property (
        !lsum[`LTST_NCH] |=> !ques_limit)
        else $error("questionable bit set without enabled event");
    ques_clr_a: assert property (
        cls_hit && !lnew[`LTST_NCH] |=> ##1 !ques_limit)
        else $error("questionable bit survived clear");

    // Register port checks
    qcond_rd_a: assert property (
        rd && addr == {`LTST_MISC_LAYER, `LTST_MISC_QCOND} |=> rdata == {5'h00, $past(ques_limit), 10'h000})
        else $error("questionable condition read wrong");
    unmapped_rd_a: assert property (
        rd && addr[5:3] > `LTST_MISC_LAYER |=> rdata == 16'h0000)
        else $error("unmapped block read nonzero");
    lay_rsvd_a: assert property (
        rd && addr[5:3] < `LTST_MISC_LAYER && addr[2:0] > `LTST_REG_NTR |=> rdata == 16'h0000)
        else $error("unused layer register read nonzero");
    misc_rsvd_a: assert property (
        rd && misc_sel && addr[2:0] > `LTST_MISC_IMASK |=> rdata == 16'h0000)
        else $error("unused control register read nonzero");

    // Interrupt checks
    irq_off_a: assert property (
        !(|(st_r.istat & st_r.imask)) |-> !irq)
        else $error("interrupt high with nothing unmasked");
    imask_wr_a: assert property (
        imask_wr |=> st_r.imask == $past(wdata[`LTST_IW-1:0]))
        else $error("interrupt mask write lost");
    imask_rd_a: assert property (
        rd && addr == {`LTST_MISC_LAYER, `LTST_MISC_IMASK} |=> rdata == {11'h000, $past(st_r.imask)})
        else $error("interrupt mask read wrong");
    istat_rd_a: assert property (
        istat_rd |=> rdata == {11'h000, $past(st_r.istat)})
        else $error("interrupt status read wrong");
    istat_clr_a: assert property (
        istat_rd && lnew[`LTST_NCH-1:0] == 4'h0 && !(lsum[`LTST_NCH] && !st_r.ques) |=> st_r.istat == 5'h00)
        else $error("interrupt status survived its read");
    istat_ques_a: assert property (
        lsum[`LTST_NCH] && !st_r.ques |=> st_r.istat[`LTST_NCH])
        else $error("questionable rise missing from status");
    istat_hold_a: assert property (
        !istat_rd |=> (st_r.istat & $past(st_r.istat)) == $past(st_r.istat))
        else $error("interrupt status bit dropped without read");

    // Main scenarios
    fail_c: cover property (meas[0].done && meas[0].fail != '0 ##3 limit_sum[1]);
    ques_c: cover property ($rose(ques_limit));
    cls_c:  cover property (ques_limit ##1 cls_hit ##3 !ques_limit);
    irq_c:  cover property ($rose(irq) ##[1:4] istat_rd ##1 !irq);
    fall_c: cover property (meas[0].start ##2 levt[0][1]);

endmodule

// File: shared/ltst_cfg.svh
// Constants of the limit test status tree: offsets, field positions, resets.
// Assumes a word-addressed register port with 16-bit data.
`ifndef LTST_CFG_SVH
`define LTST_CFG_SVH

// Sizes
`define LTST_NCH        4
`define LTST_NTRC       4
`define LTST_NLAYER     5
`define LTST_DW         16
`define LTST_AW         6
`define LTST_IW         5

// Field positions
`define LTST_TRC_LSB    1
`define LTST_TRC_MSB    4
`define LTST_QUES_BIT   10
`define LTST_SUM_LAYER  3'h4

// Address layout: addr[5:3] picks a layer, addr[2:0] a register
`define LTST_REG_COND   3'h0
`define LTST_REG_EVT    3'h1
`define LTST_REG_ENA    3'h2
`define LTST_REG_PTR    3'h3
`define LTST_REG_NTR    3'h4
`define LTST_MISC_LAYER 3'h5
`define LTST_MISC_QCOND 3'h0
`define LTST_MISC_CLS   3'h1
`define LTST_MISC_ISTAT 3'h2
`define LTST_MISC_IMASK 3'h3

// Reset values
`define LTST_ENA_RST    16'h0000
`define LTST_PTR_RST    16'hffff
`define LTST_NTR_RST    16'h0000

`endif

// File: shared/ltst_pkg.sv
// Types of the limit test status tree.
// Assumes ltst_cfg.svh is on the include path.
`include "ltst_cfg.svh"

package ltst_pkg;

    // Measurement report of one channel
    typedef struct packed {
        logic                  start;
        logic                  done;
        logic [`LTST_NTRC-1:0] fail;
    } ltst_meas_t;

    // State of one condition/event/enable layer
    typedef struct packed {
        logic [`LTST_DW-1:0] prev;
        logic [`LTST_DW-1:0] evt;
        logic [`LTST_DW-1:0] ena;
        logic [`LTST_DW-1:0] ptr;
        logic [`LTST_DW-1:0] ntr;
    } ltst_evt_st_t;

    // State of the top level
    typedef struct packed {
        logic [`LTST_NCH-1:0][`LTST_DW-1:0] cond;
        logic [`LTST_DW-1:0]                sum_cond;
        logic                               ques;
        logic [`LTST_IW-1:0]                istat;
        logic [`LTST_IW-1:0]                imask;
        logic                               irq;
        logic [`LTST_DW-1:0]                rdata;
    } ltst_top_st_t;

endpackage

// File: test/ltst_tb.sv
// Self-checking bench of the limit test status tree top level.
// Assumes ltst_cfg.svh on the include path and ltst_pkg compiled first.
`timescale 1ns/1ps
`include "ltst_cfg.svh"

module testbench;
    // Clock, reset, register port and status outputs
    logic                                 clk = 1'b0;
    logic                                 rst = 1'b1;
    logic                 [`LTST_AW-1:0]  addr = '0;
    logic                 [`LTST_DW-1:0]  wdata = '0;
    logic                                 wr = 1'b0;
    logic                                 rd = 1'b0;
    logic                 [`LTST_DW-1:0]  rdata;
    ltst_pkg::ltst_meas_t [`LTST_NCH-1:0] meas = '0;
    logic                 [`LTST_DW-1:0]  limit_sum;
    logic                                 ques_limit;
    logic                                 irq;
    // Bookkeeping
    int                                   fails = 0;
    int                                   num_checks = 0;
    int                                   cyc = 0;
    logic                 [`LTST_DW-1:0]  v;

    ltst_top i_dut (
        .clk        (clk),
        .rst        (rst),
        .addr       (addr),
        .wdata      (wdata),
        .wr         (wr),
        .rd         (rd),
        .rdata      (rdata),
        .meas       (meas),
        .limit_sum  (limit_sum),
        .ques_limit (ques_limit),
        .irq        (irq)
    );

    // 50 MHz clock
    always #10 clk = ~clk;

    // Hang guard, far above the expected run of under two hundred cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            fails = fails + 1;
            tally_and_finish();
        end
    end

    // Word address from layer and register index
    function logic [5:0] ra(input logic [2:0] l, input logic [2:0] r);
        return {l, r};
    endfunction

    // One-cycle write strobe
    task wr_reg(input logic [5:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // One-cycle read strobe; data taken in the following cycle only
    task rd_reg(input logic [5:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    // Compare one 16-bit result
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        num_checks = num_checks + 1;
        if (g !== e) begin
            fails = fails + 1;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    // Read a register and compare
    task chk_rd(input string n, input logic [5:0] a, input logic [15:0] e);
        rd_reg(a, v);
        chk(n, e, v);
    endtask

    // One-cycle measurement report on one channel
    task pulse(input int c, input logic s, input logic d, input logic [3:0] f);
        @(posedge clk);
        meas[c] <= '{start: s, done: d, fail: f};
        @(posedge clk);
        meas[c] <= '0;
    endtask

    // Let cycles pass, then step off the edge
    task idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Verdict
    task tally_and_finish();
        if (fails == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        // Reset values and an unmapped word
        chk_rd("ena0", ra(3'h0, `LTST_REG_ENA), `LTST_ENA_RST);
        chk_rd("ptr2", ra(3'h2, `LTST_REG_PTR), `LTST_PTR_RST);
        chk_rd("ntr3", ra(3'h3, `LTST_REG_NTR), `LTST_NTR_RST);
        chk_rd("imask", ra(`LTST_MISC_LAYER, `LTST_MISC_IMASK), 16'h0000);
        chk_rd("unmapped", ra(3'h6, 3'h0), 16'h0000);
        // One failing trace through both layers, interrupt masked
        wr_reg(ra(3'h0, `LTST_REG_ENA), 16'h0002);
        wr_reg(ra(`LTST_SUM_LAYER, `LTST_REG_ENA), 16'h0002);
        pulse(0, 1'b0, 1'b1, 4'h1);
        idle(8);
        chk("limit_sum", 16'h0002, limit_sum);
        chk("ques_limit", 16'h0001, {15'h0, ques_limit});
        chk("irq", 16'h0000, {15'h0, irq});
        chk_rd("cond0", ra(3'h0, `LTST_REG_COND), 16'h0002);
        chk_rd("qcond", ra(`LTST_MISC_LAYER, `LTST_MISC_QCOND), 16'h0400);
        // Read-only condition ignores a write
        wr_reg(ra(3'h0, `LTST_REG_COND), 16'hffff);
        chk_rd("cond0", ra(3'h0, `LTST_REG_COND), 16'h0002);
        // Unmask, then read-clear the interrupt status
        wr_reg(ra(`LTST_MISC_LAYER, `LTST_MISC_IMASK), 16'h0001);
        idle(3);
        chk("irq", 16'h0001, {15'h0, irq});
        chk_rd("istat", ra(`LTST_MISC_LAYER, `LTST_MISC_ISTAT), 16'h0011);
        idle(3);
        chk("irq", 16'h0000, {15'h0, irq});
        // Every channel: fail pattern loaded at done, zeroed at start
        wr_reg(ra(`LTST_SUM_LAYER, `LTST_REG_ENA), 16'h001e);
        for (int c = 0; c < 4; c++) begin
            wr_reg(ra(c[2:0], `LTST_REG_ENA), 16'h001e);
            pulse(c, 1'b0, 1'b1, 4'hf >> c);
            idle(2);
            chk_rd("cond", ra(c[2:0], `LTST_REG_COND), {11'h0, 4'hf >> c, 1'b0});
            pulse(c, 1'b1, 1'b0, 4'hf);
            idle(2);
            chk_rd("cond", ra(c[2:0], `LTST_REG_COND), 16'h0000);
        end
        idle(8);
        chk("limit_sum", 16'h001e, limit_sum);
        // Disabling channel 1 events drops its summary bit
        wr_reg(ra(3'h1, `LTST_REG_ENA), 16'h0000);
        idle(4);
        chk("limit_sum", 16'h001a, limit_sum);
        // Clear-status empties all event registers
        wr_reg(ra(`LTST_MISC_LAYER, `LTST_MISC_CLS), 16'h0001);
        for (int l = 0; l < 5; l++) begin
            chk_rd("evt", ra(l[2:0], `LTST_REG_EVT), 16'h0000);
        end
        idle(4);
        chk("limit_sum", 16'h0000, limit_sum);
        chk("ques_limit", 16'h0000, {15'h0, ques_limit});
        // Falling-edge filter only: rise ignored, fall latched
        wr_reg(ra(3'h0, `LTST_REG_PTR), 16'h0000);
        wr_reg(ra(3'h0, `LTST_REG_NTR), 16'h0002);
        pulse(0, 1'b0, 1'b1, 4'h1);
        idle(3);
        chk_rd("evt0", ra(3'h0, `LTST_REG_EVT), 16'h0000);
        pulse(0, 1'b1, 1'b0, 4'h0);
        idle(3);
        chk_rd("evt0", ra(3'h0, `LTST_REG_EVT), 16'h0002);
        tally_and_finish();
    end
endmodule
